// [logic/ifm_pkg.sv]
// Shared constants and types for the firmware master assist serial port
package ifm_pkg;
	// ==========================================================
	// Register map: printed index, byte address is index times four
	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_CORE_INT_CTRL = 8'h0B;
	localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0C;
	localparam logic [7:0] IDX_SHIFT_BUF = 8'h13;
	localparam logic [7:0] IDX_PORT_CTRL = 8'h14;
	localparam logic [7:0] IDX_PORT_C_DIR = 8'h87;
	localparam logic [7:0] IDX_PERIPH_EN = 8'h8C;
	localparam logic [7:0] IDX_OWN_ADDR = 8'h93;
	localparam logic [7:0] IDX_PORT_STAT = 8'h94;
	// ==========================================================
	// Reset values and field positions
	localparam logic [5:0] RST_PORT_C_DIR = 6'h3F;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam int BIT_EVENT = 3;
	localparam int BIT_WCOL = 7;
	localparam int BIT_OVF = 6;
	localparam int BIT_ENABLE = 5;
	localparam int BIT_SDA = 4;
	localparam int BIT_SCL = 3;
	localparam logic [3:0] MODE_SLV7 = 4'h6;
	localparam logic [3:0] MODE_SLV10 = 4'h7;
	localparam logic [3:0] MODE_FW_MASTER = 4'hB;
	localparam logic [3:0] MODE_SLV7_SS = 4'hE;
	localparam logic [3:0] MODE_SLV10_SS = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] BYTE_END = 4'h9;
	// ==========================================================
	// Link timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	// ==========================================================
	// Types
	typedef enum logic [1:0] {IFM_CMD_START, IFM_CMD_WRITE, IFM_CMD_READ, IFM_CMD_STOP} ifm_cmd_e;
	typedef enum logic [1:0] {SLV_IDLE, SLV_ADDR, SLV_RX, SLV_TX} ifm_slv_e;
	typedef enum logic [2:0] {H_IDLE, H_WAIT, H_START, H_BIT, H_STOP} ifm_hst_e;
endpackage : ifm_pkg

// [logic/ifm_link_if.sv]
// Two-wire link between the device end and the far master end
`timescale 1ns/1ns
interface ifm_link_if;
	logic dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n;
	logic host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n;
	logic scl_i, sda_i;
	// ==========================================================
	// Wired-AND with pull-up: a line is low while any enabled driver pulls it low
	assign scl_i = ~((~dev_scl_oe_n & ~dev_scl_o) | (~host_scl_oe_n & ~host_scl_o));
	assign sda_i = ~((~dev_sda_oe_n & ~dev_sda_o) | (~host_sda_oe_n & ~host_sda_o));
	modport dev (input scl_i, input sda_i, output dev_scl_o, output dev_scl_oe_n,
		output dev_sda_o, output dev_sda_oe_n);
	modport host (input scl_i, input sda_i, output host_scl_o, output host_scl_oe_n,
		output host_sda_o, output host_sda_oe_n);
endinterface : ifm_link_if

// [logic/ifm_cond_det.sv]
// Line synchroniser with start and stop condition detection
`timescale 1ns/1ns
module ifm_cond_det
	import ifm_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic clr,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_s,
	output logic sda_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_p,
	output logic stop_p,
	output logic start_seen,
	output logic stop_seen
);
	logic [2:0] scl_sh_reg;
	logic [2:0] sda_sh_reg;
	// ==========================================================
	// Two flops per line, third stage only for edge finding
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_sh_reg <= 3'h7;
			sda_sh_reg <= 3'h7;
		end else begin
			scl_sh_reg <= {scl_sh_reg[1:0], scl_i};
			sda_sh_reg <= {sda_sh_reg[1:0], sda_i};
		end
	end
	assign scl_s = scl_sh_reg[1];
	assign sda_s = sda_sh_reg[1];
	assign scl_rise = scl_sh_reg[1] & ~scl_sh_reg[2];
	assign scl_fall = ~scl_sh_reg[1] & scl_sh_reg[2];
	// SDA edge while SCL stays high
	assign start_p = scl_sh_reg[1] & scl_sh_reg[2] & ~sda_sh_reg[1] & sda_sh_reg[2];
	assign stop_p = scl_sh_reg[1] & scl_sh_reg[2] & sda_sh_reg[1] & ~sda_sh_reg[2];
	// ==========================================================
	// Seen bits replace each other; disable wipes both
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
		end else if (clr) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
		end else if (start_p) begin
			start_seen <= 1'b1;
			stop_seen <= 1'b0;
		end else if (stop_p) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b1;
		end
	end
endmodule : ifm_cond_det

// [logic/ifm_dev.sv]
// Device end: registers over AXI4-Lite, condition detection, slave logic, pins
`timescale 1ns/1ns
module ifm_dev
	import ifm_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [ADDR_W-1:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic IRQ,
	ifm_link_if.dev BUS
);
	logic aw_ready_reg, w_ready_reg, b_valid_reg, ar_ready_reg, r_valid_reg, irq_reg;
	logic [1:0] b_resp_reg, r_resp_reg;
	logic [31:0] r_data_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [7:0] w_data_reg, rd_val, cic_reg, pie_reg, own_addr_reg, tx_buf_reg, rx_buf_reg;
	logic [7:0] shift_reg;
	logic [5:0] spc_reg, dir_reg;
	logic [1:0] stat_hi_reg;
	logic [3:0] bit_cnt_reg;
	logic w_lane_reg, wr_go, wr_en, rd_buf, ev_flag_reg, wcol_reg, ovf_reg, bf_reg, rw_reg;
	logic slv_low_reg, nack_reg, byte_done_reg, rx_load_reg, ovf_ev_reg;
	logic scl_oe_n_reg, sda_oe_n_reg, enable, slave_on, cond_int, tx_busy;
	logic scl_s, sda_s, scl_rise, scl_fall, start_p, stop_p, start_seen, stop_seen;
	logic [7:0] wr_idx;
	ifm_slv_e slv_state;

	// Word-aligned hit on one of the printed indices
	function automatic logic map_hit(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[ADDR_W-1:2];
		map_hit = (a[1:0] == 2'h0) && (i == IDX_CORE_INT_CTRL || i == IDX_PERIPH_FLAGS ||
			i == IDX_SHIFT_BUF || i == IDX_PORT_CTRL || i == IDX_PORT_C_DIR ||
			i == IDX_PERIPH_EN || i == IDX_OWN_ADDR || i == IDX_PORT_STAT);
	endfunction : map_hit

	// ==========================================================
	// AXI4-Lite write: address and data taken in either order, then one response
	assign wr_go = ~aw_ready_reg & ~w_ready_reg & ~b_valid_reg;
	assign wr_idx = aw_addr_reg[ADDR_W-1:2];
	assign wr_en = wr_go & w_lane_reg & map_hit(aw_addr_reg);
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			aw_ready_reg <= 1'b1;
			w_ready_reg <= 1'b1;
			b_valid_reg <= 1'b0;
			b_resp_reg <= RESP_OKAY;
			aw_addr_reg <= '0;
			w_data_reg <= RST_ZERO;
			w_lane_reg <= 1'b0;
		end else begin
			if (AWVALID && aw_ready_reg) begin
				aw_addr_reg <= AWADDR;
				aw_ready_reg <= 1'b0;
			end
			if (WVALID && w_ready_reg) begin
				w_data_reg <= WDATA[7:0];
				w_lane_reg <= WSTRB[0]; // Only lane 0 carries register bits
				w_ready_reg <= 1'b0;
			end
			if (wr_go) begin
				b_valid_reg <= 1'b1;
				b_resp_reg <= map_hit(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end
			if (b_valid_reg && BREADY) begin
				b_valid_reg <= 1'b0;
				aw_ready_reg <= 1'b1;
				w_ready_reg <= 1'b1;
			end
		end
	end

	// Read mux; bits above the register width read as zero
	always_comb begin
		rd_val = RST_ZERO;
		case (ARADDR[ADDR_W-1:2])
			IDX_CORE_INT_CTRL: rd_val = cic_reg;
			IDX_PERIPH_FLAGS: rd_val = {4'h0, ev_flag_reg, 3'h0};
			IDX_SHIFT_BUF: rd_val = rx_buf_reg;
			IDX_PORT_CTRL: rd_val = {wcol_reg, ovf_reg, spc_reg};
			IDX_PORT_C_DIR: rd_val = {2'h0, dir_reg};
			IDX_PERIPH_EN: rd_val = pie_reg;
			IDX_OWN_ADDR: rd_val = own_addr_reg;
			IDX_PORT_STAT: rd_val = {stat_hi_reg, 1'b0, stop_seen, start_seen, rw_reg, 1'b0, bf_reg};
			default: rd_val = RST_ZERO;
		endcase
	end
	assign rd_buf = ARVALID & ar_ready_reg & map_hit(ARADDR) & (ARADDR[ADDR_W-1:2] == IDX_SHIFT_BUF);

	// ==========================================================
	// AXI4-Lite read: answer one cycle after the address is taken
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ar_ready_reg <= 1'b1;
			r_valid_reg <= 1'b0;
			r_data_reg <= 32'h00000000;
			r_resp_reg <= RESP_OKAY;
		end else if (ARVALID && ar_ready_reg) begin
			ar_ready_reg <= 1'b0;
			r_valid_reg <= 1'b1;
			r_data_reg <= map_hit(ARADDR) ? {24'h000000, rd_val} : 32'h00000000;
			r_resp_reg <= map_hit(ARADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (r_valid_reg && RREADY) begin
			r_valid_reg <= 1'b0;
			ar_ready_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			cic_reg <= RST_ZERO;
			pie_reg <= RST_ZERO;
			own_addr_reg <= RST_ZERO;
			spc_reg <= 6'h00;
			dir_reg <= RST_PORT_C_DIR;
			stat_hi_reg <= 2'h0;
			tx_buf_reg <= RST_ZERO;
		end else if (wr_en) begin
			case (wr_idx)
				IDX_CORE_INT_CTRL: cic_reg <= w_data_reg;
				IDX_PERIPH_EN: pie_reg <= w_data_reg;
				IDX_OWN_ADDR: own_addr_reg <= w_data_reg;
				IDX_PORT_CTRL: spc_reg <= w_data_reg[5:0];
				IDX_PORT_C_DIR: dir_reg <= w_data_reg[5:0];
				IDX_PORT_STAT: stat_hi_reg <= w_data_reg[7:6];
				IDX_SHIFT_BUF: if (!tx_busy) tx_buf_reg <= w_data_reg;
				default: ;
			endcase
		end
	end

	// Hardware-set flags: a set in the cycle of a clear wins
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ev_flag_reg <= 1'b0;
			wcol_reg <= 1'b0;
			ovf_reg <= 1'b0;
			bf_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			ev_flag_reg <= (cond_int & (start_p | stop_p)) | byte_done_reg |
				(ev_flag_reg & ~(wr_en && wr_idx == IDX_PERIPH_FLAGS && w_data_reg[BIT_EVENT]));
			wcol_reg <= (wr_en && wr_idx == IDX_SHIFT_BUF && tx_busy) |
				((wr_en && wr_idx == IDX_PORT_CTRL) ? w_data_reg[BIT_WCOL] : wcol_reg);
			ovf_reg <= ovf_ev_reg | ((wr_en && wr_idx == IDX_PORT_CTRL) ? w_data_reg[BIT_OVF] : ovf_reg);
			bf_reg <= rx_load_reg | (bf_reg & ~rd_buf);
			irq_reg <= ev_flag_reg & pie_reg[BIT_EVENT];
		end
	end

	// ==========================================================
	// Mode decode: 1011 leaves the slave idle but keeps condition interrupts
	assign enable = spc_reg[BIT_ENABLE];
	assign slave_on = enable & (spc_reg[3:0] == MODE_SLV7 || spc_reg[3:0] == MODE_SLV10 ||
		spc_reg[3:0] == MODE_SLV7_SS || spc_reg[3:0] == MODE_SLV10_SS);
	assign cond_int = enable & (spc_reg[3:0] == MODE_FW_MASTER || spc_reg[3:0] == MODE_SLV7_SS ||
		spc_reg[3:0] == MODE_SLV10_SS);
	assign tx_busy = (slv_state == SLV_TX) && (bit_cnt_reg < ACK_SLOT);

	ifm_cond_det u_det (
		.clk(CORE_CLK),
		.nrst(NRST),
		.clr(~enable),
		.scl_i(BUS.scl_i),
		.sda_i(BUS.sda_i),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_p(start_p),
		.stop_p(stop_p),
		.start_seen(start_seen),
		.stop_seen(stop_seen)
	);

	// ==========================================================
	// Slave: listens only in the four slave modes; idle in firmware master mode 1011
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			slv_state <= SLV_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= RST_ZERO;
			rx_buf_reg <= RST_ZERO;
			slv_low_reg <= 1'b0;
			nack_reg <= 1'b0;
			rw_reg <= 1'b0;
			byte_done_reg <= 1'b0;
			rx_load_reg <= 1'b0;
			ovf_ev_reg <= 1'b0;
		end else begin
			byte_done_reg <= 1'b0;
			rx_load_reg <= 1'b0;
			ovf_ev_reg <= 1'b0;
			if (!slave_on || stop_p) begin
				slv_state <= SLV_IDLE;
				slv_low_reg <= 1'b0;
			end else if (start_p) begin
				slv_state <= SLV_ADDR;
				bit_cnt_reg <= 4'h0;
				slv_low_reg <= 1'b0;
			end else if (slv_state != SLV_IDLE && scl_rise) begin
				if (bit_cnt_reg < ACK_SLOT)
					shift_reg <= {shift_reg[6:0], sda_s};
				if (bit_cnt_reg == ACK_SLOT)
					nack_reg <= sda_s;
				if (bit_cnt_reg != BYTE_END)
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end else if (slv_state != SLV_IDLE && scl_fall) begin
				if (bit_cnt_reg == ACK_SLOT) begin
					case (slv_state)
						SLV_ADDR: begin
							if (shift_reg[7:1] == own_addr_reg[7:1]) begin
								slv_low_reg <= 1'b1;
								rw_reg <= shift_reg[0];
								byte_done_reg <= 1'b1;
							end else begin
								slv_state <= SLV_IDLE;
							end
						end
						SLV_RX: begin
							slv_low_reg <= ~bf_reg; // Refuse a byte that would overwrite
							byte_done_reg <= 1'b1;
							rx_load_reg <= ~bf_reg;
							ovf_ev_reg <= bf_reg;
							if (!bf_reg)
								rx_buf_reg <= shift_reg;
						end
						default: begin
							slv_low_reg <= 1'b0;
							byte_done_reg <= 1'b1;
						end
					endcase
				end else if (bit_cnt_reg == BYTE_END) begin
					bit_cnt_reg <= 4'h0;
					if ((slv_state == SLV_ADDR && rw_reg) || (slv_state == SLV_TX && !nack_reg)) begin
						slv_state <= SLV_TX;
						shift_reg <= tx_buf_reg;
						slv_low_reg <= ~tx_buf_reg[7];
					end else begin
						slv_state <= (slv_state == SLV_ADDR) ? SLV_RX : (slv_state == SLV_TX) ?
							SLV_IDLE : slv_state;
						slv_low_reg <= 1'b0;
					end
				end else if (slv_state == SLV_TX) begin
					slv_low_reg <= ~shift_reg[7];
				end
			end
		end
	end

	// ==========================================================
	// Pins only ever pull low; the data latch plays no part
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			scl_oe_n_reg <= 1'b1;
			sda_oe_n_reg <= 1'b1;
		end else begin
			scl_oe_n_reg <= dir_reg[BIT_SCL];
			sda_oe_n_reg <= dir_reg[BIT_SDA] & ~slv_low_reg;
		end
	end
	assign BUS.dev_scl_o = 1'b0;
	assign BUS.dev_sda_o = 1'b0;
	assign BUS.dev_scl_oe_n = scl_oe_n_reg;
	assign BUS.dev_sda_oe_n = sda_oe_n_reg;
	assign AWREADY = aw_ready_reg;
	assign WREADY = w_ready_reg;
	assign BVALID = b_valid_reg;
	assign BRESP = b_resp_reg;
	assign ARREADY = ar_ready_reg;
	assign RVALID = r_valid_reg;
	assign RDATA = r_data_reg;
	assign RRESP = r_resp_reg;
	assign IRQ = irq_reg;
endmodule : ifm_dev

// [logic/ifm_host.sv]
// Far end: competing bus master that makes SCL by dividing its own clock
`timescale 1ns/1ns
module ifm_host
	import ifm_pkg::*;
#(
	parameter int QUARTER_CYC = SCL_QUARTER_CYC
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire ifm_cmd_e CMD,
	input wire logic [7:0] CMD_DATA,
	input wire logic CMD_ACK,
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA,
	output logic RSP_NACK,
	output logic RSP_LOST,
	ifm_link_if.host BUS
);
	ifm_hst_e state;
	logic [15:0] q_cnt_reg;
	logic [1:0] phase_reg;
	logic [3:0] bit_reg;
	logic [7:0] shift_reg;
	logic rd_reg, ack_out_reg, own_reg, scl_rel_reg, sda_rel_reg, cmd_ready_reg;
	logic rsp_valid_reg, rsp_nack_reg, rsp_lost_reg, tick;
	logic scl_s, sda_s, start_seen;

	ifm_cond_det u_det (
		.clk(CORE_CLK),
		.nrst(NRST),
		.clr(1'b0),
		.scl_i(BUS.scl_i),
		.sda_i(BUS.sda_i),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_rise(),
		.scl_fall(),
		.start_p(),
		.stop_p(),
		.start_seen(start_seen),
		.stop_seen()
	);

	// Quarter-period divider; four quarters make one SCL period
	assign tick = q_cnt_reg == 16'(QUARTER_CYC - 1);

	// ==========================================================
	// Command sequencer
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			state <= H_IDLE;
			q_cnt_reg <= 16'h0000;
			phase_reg <= 2'h0;
			bit_reg <= 4'h0;
			shift_reg <= 8'h00;
			rd_reg <= 1'b0;
			ack_out_reg <= 1'b0;
			own_reg <= 1'b0;
			scl_rel_reg <= 1'b1;
			sda_rel_reg <= 1'b1;
			cmd_ready_reg <= 1'b1;
			rsp_valid_reg <= 1'b0;
			rsp_nack_reg <= 1'b0;
			rsp_lost_reg <= 1'b0;
		end else begin
			rsp_valid_reg <= 1'b0;
			q_cnt_reg <= (state == H_IDLE || state == H_WAIT || tick) ? 16'h0000 : q_cnt_reg + 16'h0001;
			if (state != H_IDLE && state != H_WAIT && tick)
				phase_reg <= phase_reg + 2'h1;
			case (state)
				H_IDLE: begin
					phase_reg <= 2'h0;
					if (CMD_VALID && cmd_ready_reg) begin
						cmd_ready_reg <= 1'b0;
						shift_reg <= CMD_DATA;
						rd_reg <= (CMD == IFM_CMD_READ);
						ack_out_reg <= CMD_ACK;
						bit_reg <= 4'h0;
						case (CMD)
							IFM_CMD_START: state <= own_reg ? H_START : H_WAIT;
							IFM_CMD_STOP: state <= H_STOP;
							default: state <= H_BIT;
						endcase
					end
				end
				// Bus free: stop seen last, or no condition seen at all
				H_WAIT: if (!start_seen && scl_s && sda_s) state <= H_START;
				H_START: if (tick) begin
					case (phase_reg)
						2'h0: sda_rel_reg <= 1'b1;
						2'h1: scl_rel_reg <= 1'b1;
						2'h2: sda_rel_reg <= 1'b0;
						default: begin
							scl_rel_reg <= 1'b0;
							own_reg <= 1'b1;
							state <= H_IDLE;
							rsp_valid_reg <= 1'b1;
							rsp_lost_reg <= 1'b0;
							cmd_ready_reg <= 1'b1;
						end
					endcase
				end
				H_STOP: if (tick) begin
					case (phase_reg)
						2'h0: sda_rel_reg <= 1'b0;
						2'h1: scl_rel_reg <= 1'b1;
						2'h2: sda_rel_reg <= 1'b1;
						default: begin
							own_reg <= 1'b0;
							state <= H_IDLE;
							rsp_valid_reg <= 1'b1;
							rsp_lost_reg <= 1'b0;
							cmd_ready_reg <= 1'b1;
						end
					endcase
				end
				H_BIT: if (tick) begin
					case (phase_reg)
						// SDA changes only while SCL is low; one is a released line
						2'h0: sda_rel_reg <= rd_reg ? (bit_reg == ACK_SLOT ? ~ack_out_reg : 1'b1) :
							(bit_reg == ACK_SLOT ? 1'b1 : shift_reg[7]);
						2'h1: scl_rel_reg <= 1'b1;
						2'h2: ;
						default: begin
							scl_rel_reg <= 1'b0;
							if (!rd_reg && bit_reg != ACK_SLOT && sda_rel_reg && !sda_s) begin
								scl_rel_reg <= 1'b1;
								sda_rel_reg <= 1'b1;
								own_reg <= 1'b0;
								state <= H_IDLE;
								rsp_valid_reg <= 1'b1;
								rsp_lost_reg <= 1'b1;
								cmd_ready_reg <= 1'b1;
							end else if (bit_reg == ACK_SLOT) begin
								state <= H_IDLE;
								rsp_valid_reg <= 1'b1;
								rsp_nack_reg <= sda_s;
								rsp_lost_reg <= 1'b0;
								cmd_ready_reg <= 1'b1;
							end else begin
								shift_reg <= {shift_reg[6:0], sda_s};
								bit_reg <= bit_reg + 4'h1;
							end
						end
					endcase
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	assign BUS.host_scl_o = 1'b0;
	assign BUS.host_sda_o = 1'b0;
	assign BUS.host_scl_oe_n = scl_rel_reg;
	assign BUS.host_sda_oe_n = sda_rel_reg;
	assign CMD_READY = cmd_ready_reg;
	assign RSP_VALID = rsp_valid_reg;
	assign RSP_DATA = shift_reg;
	assign RSP_NACK = rsp_nack_reg;
	assign RSP_LOST = rsp_lost_reg;
endmodule : ifm_host

// [tb/ifm_link_checker.sv]
// Assertions on the two-wire link between the device end and the far master
`timescale 1ns/1ns
module ifm_link_checker (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic dev_scl_o,
	input wire logic dev_scl_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic host_scl_o,
	input wire logic host_scl_oe_n,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic scl_i,
	input wire logic sda_i
);
	// ==========================================================
	// Link checks, all sampled on the core clock
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	dev_low_a: assert property (dev_scl_o == 1'b0 && dev_sda_o == 1'b0)
		else $error("device drives a line high");
	host_low_a: assert property (host_scl_o == 1'b0 && host_sda_o == 1'b0)
		else $error("far master drives a line high");
	sda_pull_a: assert property (!dev_sda_oe_n |-> !sda_i)
		else $error("sda not low while device pulls");
	scl_pull_a: assert property (!dev_scl_oe_n |-> !scl_i)
		else $error("scl not low while device pulls");
	sda_float_a: assert property (dev_sda_oe_n && host_sda_oe_n |-> sda_i)
		else $error("released sda not high");
	// Start: SCL follows SDA low within four cycles, one quarter here, never left high
	start_shape_a: assert property ($fell(host_sda_oe_n) && scl_i |-> ##[1:4] !host_scl_oe_n)
		else $error("start not followed by scl low");
	// After a stop the far master leaves both lines alone for a while
	stop_idle_a: assert property ($rose(host_sda_oe_n) && scl_i |=> (host_scl_oe_n && host_sda_oe_n)[*3])
		else $error("bus touched right after stop");
	// An acknowledge or data bit is held across the whole SCL high phase
	ack_hold_a: assert property ($fell(dev_sda_oe_n) && !scl_i
		|-> !dev_sda_oe_n throughout (##[1:12] scl_i ##[1:12] !scl_i))
		else $error("device sda released during clock high");
endmodule : ifm_link_checker

// [tb/tb.sv]
// Bench: device end and far master joined, device registers over AXI4-Lite
`timescale 1ns/1ns
module tb import ifm_pkg::*;;
	logic CORE_CLK, NRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY, IRQ;
	logic [ADDR_W-1:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, r;
	logic CMD_VALID, CMD_READY, CMD_ACK, RSP_VALID, RSP_NACK, RSP_LOST;
	ifm_cmd_e CMD;
	logic [7:0] CMD_DATA, RSP_DATA, d;
	int n_errors, samples_checked;
	ifm_link_if lk();
	// ==========================================================
	// Both link ends; the far master runs a 320 ns SCL so the slave's
	// four-cycle reaction to an SCL fall settles well before SCL rises again
	ifm_dev ifm_dev_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
		.IRQ(IRQ), .BUS(lk));
	ifm_host #(.QUARTER_CYC(4)) ifm_host_i (.CORE_CLK(CORE_CLK), .NRST(NRST),
		.CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(CMD), .CMD_DATA(CMD_DATA),
		.CMD_ACK(CMD_ACK), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .RSP_NACK(RSP_NACK),
		.RSP_LOST(RSP_LOST), .BUS(lk));
	ifm_link_checker ifm_link_checker_i (.CORE_CLK(CORE_CLK), .NRST(NRST),
		.dev_scl_o(lk.dev_scl_o), .dev_scl_oe_n(lk.dev_scl_oe_n), .dev_sda_o(lk.dev_sda_o),
		.dev_sda_oe_n(lk.dev_sda_oe_n), .host_scl_o(lk.host_scl_o),
		.host_scl_oe_n(lk.host_scl_oe_n), .host_sda_o(lk.host_sda_o),
		.host_sda_oe_n(lk.host_sda_oe_n), .scl_i(lk.scl_i), .sda_i(lk.sda_i));
	// Verdict, also reached when a wait runs out
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask : chk
	task automatic hang(input int k, input int lim);
		if (k >= lim) begin
			n_errors++;
			$display("wrong value at %0t: no answer", $time);
			close_out();
		end
	endtask : hang
	// Write: address and data offered together; BREADY stays high throughout
	task automatic wr(input logic [7:0] x, input logic [7:0] v);
		int k;
		AWADDR <= {x, 2'b00};
		WDATA <= {24'h000000, v};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge CORE_CLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
			if (BVALID) break;
		end
		hang(k, 100);
	endtask : wr
	task automatic rd(input logic [7:0] x, output logic [7:0] v, output logic [1:0] rs);
		int k;
		ARADDR <= {x, 2'b00};
		ARVALID <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge CORE_CLK);
			if (ARREADY) ARVALID <= 1'b0;
			if (RVALID) break;
		end
		v = RDATA[7:0];
		rs = RRESP;
		hang(k, 100);
	endtask : rd
	task automatic rc(input logic [7:0] x, input logic [7:0] e, input string m);
		rd(x, d, r);
		chk({r, d}, {RESP_OKAY, e}, m);
	endtask : rc
	// Far master command: held until taken, then wait for its one-cycle answer
	task automatic hc(input ifm_cmd_e c, input logic [7:0] v, input logic a);
		int k;
		logic t;
		t = 1'b0;
		CMD <= c;
		CMD_DATA <= v;
		CMD_ACK <= a;
		CMD_VALID <= 1'b1;
		for (k = 0; k < 3000; k++) begin
			@(posedge CORE_CLK);
			if (t && RSP_VALID) break;
			if (CMD_READY) begin
				CMD_VALID <= 1'b0;
				t = 1'b1;
			end
		end
		hang(k, 3000);
	endtask : hc
	// 50 MHz core clock
	initial begin
		CORE_CLK = 1'b0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end
	// Main sequence
	initial begin
		NRST = 1'b0;
		{AWVALID, WVALID, ARVALID, CMD_VALID, CMD_ACK} = 5'h00;
		{BREADY, RREADY} = 2'h3;
		{AWADDR, ARADDR, WDATA, CMD_DATA} = '0;
		WSTRB = 4'hF;
		CMD = IFM_CMD_START;
		n_errors = 0;
		samples_checked = 0;
		repeat (16) @(posedge CORE_CLK);
		NRST <= 1'b1;
		@(posedge CORE_CLK);
		rc(IDX_PORT_CTRL, 8'h00, "ctrl rst");
		rc(IDX_PORT_STAT, 8'h00, "stat rst");
		rc(IDX_PORT_C_DIR, 8'h3F, "dir rst");
		rc(IDX_PERIPH_FLAGS, 8'h00, "flag rst");
		rc(IDX_PERIPH_EN, 8'h00, "en rst");
		rd(8'hFF, d, r);
		chk({r, d}, {RESP_SLVERR, 8'h00}, "unmapped");
		$display("test reset done");
		// Firmware master: pull then release SDA through the direction register
		wr(IDX_PORT_CTRL, 8'h2B);
		wr(IDX_PERIPH_EN, 8'h08);
		wr(IDX_PORT_C_DIR, 8'h2F);
		repeat (6) @(posedge CORE_CLK);
		chk(lk.sda_i, 1'b0, "sda pulled");
		rc(IDX_PORT_STAT, 8'h08, "start seen");
		chk(IRQ, 1'b1, "irq at start");
		wr(IDX_PERIPH_FLAGS, 8'h08);
		wr(IDX_PORT_C_DIR, 8'h3F);
		repeat (6) @(posedge CORE_CLK);
		chk(lk.sda_i, 1'b1, "sda freed");
		rc(IDX_PORT_STAT, 8'h10, "stop seen");
		rc(IDX_PERIPH_FLAGS, 8'h08, "flag at stop");
		wr(IDX_PERIPH_FLAGS, 8'h08);
		wr(IDX_PORT_CTRL, 8'h00);
		rc(IDX_PORT_STAT, 8'h00, "disabled");
		$display("test firmware master done");
		// Enable while the bus is busy: interrupt comes at the next stop
		wr(IDX_PERIPH_EN, 8'h00);
		wr(IDX_PORT_CTRL, 8'h2B);
		hc(IFM_CMD_START, 8'h00, 1'b0);
		repeat (6) @(posedge CORE_CLK);
		rc(IDX_PERIPH_FLAGS, 8'h08, "flag at start");
		chk(IRQ, 1'b0, "irq masked");
		wr(IDX_PERIPH_FLAGS, 8'h08);
		wr(IDX_PERIPH_EN, 8'h08);
		hc(IFM_CMD_STOP, 8'h00, 1'b0);
		repeat (6) @(posedge CORE_CLK);
		chk(IRQ, 1'b1, "irq at stop");
		rc(IDX_PORT_STAT, 8'h10, "stop seen");
		wr(IDX_PERIPH_FLAGS, 8'h08);
		$display("test busy enable done");
		// Slave answers only its own address; a read turns round at once
		wr(IDX_PORT_CTRL, 8'h26);
		wr(IDX_OWN_ADDR, 8'h84);
		wr(IDX_SHIFT_BUF, 8'hA5);
		hc(IFM_CMD_START, 8'h00, 1'b0);
		hc(IFM_CMD_WRITE, 8'h86, 1'b0);
		chk(RSP_NACK, 1'b1, "other address");
		hc(IFM_CMD_STOP, 8'h00, 1'b0);
		wr(IDX_PERIPH_FLAGS, 8'h08);
		hc(IFM_CMD_START, 8'h00, 1'b0);
		hc(IFM_CMD_WRITE, 8'h84, 1'b0);
		chk(RSP_NACK, 1'b0, "own address");
		rc(IDX_PERIPH_FLAGS, 8'h08, "byte end");
		hc(IFM_CMD_START, 8'h00, 1'b0);
		hc(IFM_CMD_WRITE, 8'h85, 1'b0);
		chk(RSP_NACK, 1'b0, "read address");
		rd(IDX_PORT_STAT, d, r);
		chk(d[2], 1'b1, "read direction");
		hc(IFM_CMD_READ, 8'h00, 1'b0);
		chk(RSP_DATA, 8'hA5, "read byte");
		hc(IFM_CMD_STOP, 8'h00, 1'b0);
		$display("test slave done");
		close_out();
	end
endmodule : tb
